// ===== hw/qpi_pkg.sv
// constants and types for the four-lane flash command framing block
package qpi_pkg;
  // opcodes
  localparam logic [7:0] OP_VSR_WREN = 8'h50;
  localparam logic [7:0] OP_CFG_RD_A = 8'h45;
  localparam logic [7:0] OP_CFG_RD_B = 8'h15;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_WRAP_READ = 8'h0C;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_WORD_READ = 8'hE7;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_PAGE_WRITE = 8'hA5;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_QPI_ENABLE = 8'h38;
  localparam logic [7:0] OP_QPI_DISABLE = 8'hFF;
  // dummy clock counts
  localparam logic [4:0] DUMMY_SPI_FAST = 5'h08;
  localparam logic [4:0] DUMMY_QPI_FAST = 5'h04;
  localparam logic [4:0] DUMMY_QUAD_IO = 5'h04;
  localparam logic [4:0] DUMMY_WORD = 5'h02;
  localparam logic [4:0] DUMMY_REL_QPI = 5'h06;
  localparam logic [4:0] DUMMY_REL_SPI = 5'h18;
  // frame lengths in bits
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] ADDR_MODE_BITS = 6'h20;
  // security register address fields
  localparam logic [7:0] SEC_UPPER = 8'h00;
  localparam logic [1:0] SEC_GAP = 2'h0;
  localparam logic [3:0] SEC_FIRST = 4'h1;
  localparam logic [3:0] SEC_LAST = 4'h3;
  // value after reset, and lane counts
  localparam logic QPI_AT_RESET = 1'b1;
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;

  typedef enum logic [1:0] {SRC_NONE, SRC_CFG, SRC_ID, SRC_MEM} src_t;

  typedef struct packed {
    logic has_addr;
    logic has_mode;
    logic [4:0] dummy;
    logic [2:0] aw;
    logic [2:0] dw;
    src_t src;
  } cmd_info_t;
endpackage

// ===== hw/sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock, // block clock
  input wire logic arst_n, // async reset, active low
  input wire logic [WIDTH-1:0] d, // asynchronous input
  output logic [WIDTH-1:0] q // synchronised output
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== hw/qpi_flash_command_framing.sv
// serial flash command framing for single, two and four lane transfers
`timescale 1ns/1ns
module qpi_flash_command_framing #(
  parameter logic [7:0] DEVICE_ID = 8'h5A // arbitrary id value
) (
  input wire logic clock, // 20 MHz block clock
  input wire logic arst_n, // async reset, active low
  input wire logic sclk, // serial clock pin
  input wire logic cs_n, // chip select pin, active low
  input wire logic [3:0] io_in, // lane input levels
  output logic [3:0] io_out, // lane drive values
  output logic [3:0] io_oe, // lane drive enables
  input wire logic [7:0] cfg_value, // configuration bits to return
  input wire logic [7:0] rd_data, // byte at rd_addr
  output logic rd_take, // rd_data consumed
  output logic [23:0] rd_addr, // current read address
  output logic cmd_strobe, // command byte received
  output logic [7:0] cmd_code, // last command byte
  output logic addr_strobe, // address phase done
  output logic [23:0] addr, // captured address
  output logic [7:0] mode_bits, // captured mode bits
  output logic sec_valid, // address is a legal security address
  output logic [1:0] sec_sel, // security register number
  output logic [9:0] sec_offset, // byte within security register
  output logic qpi_mode, // four-lane command entry active
  output logic power_down, // deep power-down state
  output logic wake, // release command seen
  output logic vsr_armed // next status write is volatile
);
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DOUT, ST_SINK} state_t;

  logic sclk_s, cs_n_s, sclk_d_r, cs_n_d_r;
  logic [3:0] io_s;
  state_t state_r, state_nxt;
  logic [31:0] in_sh_r, in_next;
  logic [5:0] cnt_r, bits_next, addr_len;
  logic [4:0] dcnt_r;
  qpi_pkg::cmd_info_t info_r, new_info;
  logic [7:0] cmd_r, out_sh_r, load_byte;
  logic [3:0] ocnt_r;
  logic cmd_seen_r, extra_r, qpi_r, dpd_r, vsr_r;
  logic [2:0] cur_w;
  logic rise, fall, cs_end, cmd_done, addr_done, dummy_done, single, is_sec;
  logic [23:0] addr_cap;
  logic [7:0] mode_cap;

  // lane value gathered this clock, right aligned
  function automatic logic [3:0] in_bits(input logic [3:0] io, input logic [2:0] w);
    unique case (w)
      qpi_pkg::LANES_4: return io;
      qpi_pkg::LANES_2: return {2'h0, io[1:0]};
      default: return {3'h0, io[0]};
    endcase
  endfunction

  // top bits of a byte placed on the output lanes
  function automatic logic [3:0] lanes_out(input logic [7:0] b, input logic [2:0] w);
    unique case (w)
      qpi_pkg::LANES_4: return b[7:4];
      qpi_pkg::LANES_2: return {2'h0, b[7:6]};
      default: return {2'h0, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] oe_of(input logic [2:0] w);
    unique case (w)
      qpi_pkg::LANES_4: return 4'hF;
      qpi_pkg::LANES_2: return 4'h3;
      default: return 4'h2;
    endcase
  endfunction

  // phase after address: dummy clocks, data out or sink
  function automatic state_t after_addr(input qpi_pkg::cmd_info_t i);
    if (i.dummy != 5'h00)
      return ST_DUMMY;
    else if (i.src != qpi_pkg::SRC_NONE)
      return ST_DOUT;
    return ST_SINK;
  endfunction

  // framing of each command; in power-down only release decodes
  function automatic qpi_pkg::cmd_info_t decode(input logic [7:0] op, input logic q, input logic pd);
    qpi_pkg::cmd_info_t i;
    logic [2:0] w;
    logic [4:0] fast;
    w = q ? qpi_pkg::LANES_4 : qpi_pkg::LANES_1;
    fast = q ? qpi_pkg::DUMMY_QPI_FAST : qpi_pkg::DUMMY_SPI_FAST;
    i = '{1'b0, 1'b0, 5'h00, w, w, qpi_pkg::SRC_NONE};
    if (!pd || op == qpi_pkg::OP_RELEASE)
    begin
      case (op)
        qpi_pkg::OP_CFG_RD_A, qpi_pkg::OP_CFG_RD_B: i.src = qpi_pkg::SRC_CFG;
        qpi_pkg::OP_RELEASE:
        begin
          i.dummy = q ? qpi_pkg::DUMMY_REL_QPI : qpi_pkg::DUMMY_REL_SPI;
          i.src = qpi_pkg::SRC_ID;
        end
        qpi_pkg::OP_READ: i = '{1'b1, 1'b0, 5'h00, w, w, qpi_pkg::SRC_MEM};
        qpi_pkg::OP_FAST_READ, qpi_pkg::OP_WRAP_READ, qpi_pkg::OP_SEC_READ:
          i = '{1'b1, 1'b0, fast, w, w, qpi_pkg::SRC_MEM};
        qpi_pkg::OP_DUAL_OUT:
          i = '{1'b1, 1'b0, qpi_pkg::DUMMY_SPI_FAST, w, qpi_pkg::LANES_2, qpi_pkg::SRC_MEM};
        qpi_pkg::OP_QUAD_OUT:
          i = '{1'b1, 1'b0, qpi_pkg::DUMMY_SPI_FAST, w, qpi_pkg::LANES_4, qpi_pkg::SRC_MEM};
        qpi_pkg::OP_DUAL_IO:
          i = '{1'b1, 1'b1, 5'h00, qpi_pkg::LANES_2, qpi_pkg::LANES_2, qpi_pkg::SRC_MEM};
        qpi_pkg::OP_QUAD_IO:
          i = '{1'b1, 1'b1, qpi_pkg::DUMMY_QUAD_IO, qpi_pkg::LANES_4, qpi_pkg::LANES_4, qpi_pkg::SRC_MEM};
        qpi_pkg::OP_WORD_READ:
          i = '{1'b1, 1'b1, qpi_pkg::DUMMY_WORD, qpi_pkg::LANES_4, qpi_pkg::LANES_4, qpi_pkg::SRC_MEM};
        qpi_pkg::OP_SEC_ERASE, qpi_pkg::OP_SEC_PROG, qpi_pkg::OP_PAGE_PROG, qpi_pkg::OP_PAGE_WRITE,
        qpi_pkg::OP_PAGE_ERASE, qpi_pkg::OP_SECT_ERASE, qpi_pkg::OP_BLK32_ERASE, qpi_pkg::OP_BLK64_ERASE:
          i.has_addr = 1'b1;
        default: i.src = qpi_pkg::SRC_NONE;
      endcase
    end
    return i;
  endfunction

  sync2 #(.WIDTH(6), .RESET_VAL(6'h20)) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .d({cs_n, sclk, io_in}),
    .q({cs_n_s, sclk_s, io_s})
  );

  // edge finding on synchronised pins
  assign rise = !cs_n_s && sclk_s && !sclk_d_r;
  assign fall = !cs_n_s && !sclk_s && sclk_d_r;
  assign cs_end = cs_n_s && !cs_n_d_r;

  // command byte in two clocks on four lanes, high nibble first
  assign cur_w = (state_r == ST_ADDR) ? info_r.aw : (qpi_r ? qpi_pkg::LANES_4 : qpi_pkg::LANES_1);
  // lane n lands on bit positions n modulo the lane count
  assign in_next = (in_sh_r << cur_w) | {28'h0, in_bits(io_s, cur_w)};
  assign bits_next = cnt_r + {3'h0, cur_w};
  assign new_info = decode(in_next[7:0], qpi_r, dpd_r);
  assign addr_len = info_r.has_mode ? qpi_pkg::ADDR_MODE_BITS : qpi_pkg::ADDR_BITS;
  assign cmd_done = rise && state_r == ST_CMD && bits_next == qpi_pkg::CMD_BITS;
  assign addr_done = rise && state_r == ST_ADDR && bits_next == addr_len;
  // dummy clock lane values are never read
  assign dummy_done = rise && state_r == ST_DUMMY && dcnt_r == info_r.dummy - 5'h01;
  assign addr_cap = info_r.has_mode ? in_next[31:8] : in_next[23:0];
  assign mode_cap = info_r.has_mode ? in_next[7:0] : 8'h00;
  assign single = cmd_seen_r && !extra_r;
  assign is_sec = cmd_r == qpi_pkg::OP_SEC_READ || cmd_r == qpi_pkg::OP_SEC_ERASE
    || cmd_r == qpi_pkg::OP_SEC_PROG;
  assign load_byte = (info_r.src == qpi_pkg::SRC_CFG) ? cfg_value
    : (info_r.src == qpi_pkg::SRC_ID) ? DEVICE_ID : rd_data;

  // phase sequencing
  always_comb
  begin
    state_nxt = state_r;
    if (cs_n_s)
      state_nxt = ST_CMD;
    else if (cmd_done)
      state_nxt = new_info.has_addr ? ST_ADDR : after_addr(new_info);
    else if (addr_done)
      state_nxt = after_addr(info_r);
    else if (dummy_done)
      state_nxt = (info_r.src != qpi_pkg::SRC_NONE) ? ST_DOUT : ST_SINK;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_CMD;
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  // input shifting and bit counting, cleared while deselected
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_sh_r <= 32'h0;
      cnt_r <= 6'h00;
      dcnt_r <= 5'h00;
    end
    else if (cs_n_s || cmd_done || addr_done)
    begin
      in_sh_r <= 32'h0;
      cnt_r <= 6'h00;
      dcnt_r <= 5'h00;
    end
    else if (rise)
    begin
      in_sh_r <= in_next;
      cnt_r <= bits_next;
      dcnt_r <= (state_r == ST_DUMMY) ? dcnt_r + 5'h01 : dcnt_r;
    end
  end

  // command and address capture, user strobes
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      info_r <= '{1'b0, 1'b0, 5'h00, qpi_pkg::LANES_1, qpi_pkg::LANES_1, qpi_pkg::SRC_NONE};
      cmd_r <= 8'h00;
      cmd_seen_r <= 1'b0;
      extra_r <= 1'b0;
      cmd_strobe <= 1'b0;
      addr_strobe <= 1'b0;
      addr <= 24'h0;
      mode_bits <= 8'h00;
      wake <= 1'b0;
    end
    else
    begin
      cmd_strobe <= cmd_done;
      addr_strobe <= addr_done;
      // release byte wakes the device on its own
      wake <= cmd_done && in_next[7:0] == qpi_pkg::OP_RELEASE;
      if (cs_n_s)
      begin
        cmd_seen_r <= 1'b0;
        extra_r <= 1'b0;
      end
      else if (cmd_done)
      begin
        info_r <= new_info;
        cmd_r <= in_next[7:0];
        cmd_seen_r <= 1'b1;
      end
      else if (rise && cmd_seen_r)
        extra_r <= 1'b1;
      if (addr_done)
      begin
        addr <= addr_cap;
        mode_bits <= mode_cap;
      end
    end
  end

  // security register decode at the end of the address
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sec_valid <= 1'b0;
      sec_sel <= 2'h0;
      sec_offset <= 10'h000;
    end
    else if (addr_done)
    begin
      // upper byte and bits 11..10 zero
      // bits 15..12 pick register one to three
      sec_valid <= is_sec && addr_cap[23:16] == qpi_pkg::SEC_UPPER && addr_cap[11:10] == qpi_pkg::SEC_GAP
        && addr_cap[15:12] >= qpi_pkg::SEC_FIRST && addr_cap[15:12] <= qpi_pkg::SEC_LAST;
      sec_sel <= addr_cap[13:12];
      sec_offset <= addr_cap[9:0];
    end
  end

  // mode flags updated when select rises, lone bytes only except vsr_r, which any other command clears; release clears power-down as its byte completes
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      qpi_r <= qpi_pkg::QPI_AT_RESET;
      dpd_r <= 1'b0;
      vsr_r <= 1'b0;
    end
    else
    begin
      if (cmd_done && in_next[7:0] == qpi_pkg::OP_RELEASE)
        dpd_r <= 1'b0;
      else if (cs_end && single && cmd_r == qpi_pkg::OP_POWER_DOWN)
        dpd_r <= 1'b1;
      // lone disable byte leaves four-lane entry
      if (cs_end && single && !dpd_r && qpi_r && cmd_r == qpi_pkg::OP_QPI_DISABLE)
        qpi_r <= 1'b0;
      else if (cs_end && single && !dpd_r && !qpi_r && cmd_r == qpi_pkg::OP_QPI_ENABLE)
        qpi_r <= 1'b1;
      if (cs_end && cmd_seen_r)
        vsr_r <= single && !dpd_r && cmd_r == qpi_pkg::OP_VSR_WREN;
    end
  end

  // output lanes change on the falling serial clock edge
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      out_sh_r <= 8'h00;
      ocnt_r <= 4'h0;
      rd_addr <= 24'h0;
      rd_take <= 1'b0;
    end
    else
    begin
      rd_take <= 1'b0;
      if (cs_n_s)
      begin
        io_oe <= 4'h0;
        ocnt_r <= 4'h0;
      end
      else if (addr_done)
        rd_addr <= addr_cap;
      else if (fall && state_r == ST_DOUT)
      begin
        io_oe <= oe_of(info_r.dw);
        // two lanes, bits 7 and 6 first
        if (ocnt_r == 4'h0)
        begin
          io_out <= lanes_out(load_byte, info_r.dw);
          out_sh_r <= load_byte << info_r.dw;
          ocnt_r <= 4'h8 - {1'b0, info_r.dw};
          rd_take <= info_r.src == qpi_pkg::SRC_MEM;
          rd_addr <= (info_r.src == qpi_pkg::SRC_MEM) ? rd_addr + 24'h1 : rd_addr;
        end
        else
        begin
          io_out <= lanes_out(out_sh_r, info_r.dw);
          out_sh_r <= out_sh_r << info_r.dw;
          ocnt_r <= ocnt_r - {1'b0, info_r.dw};
        end
      end
    end
  end

  // last command byte held for the user side
  assign cmd_code = cmd_r;
  assign qpi_mode = qpi_r;
  assign power_down = dpd_r;
  assign vsr_armed = vsr_r;
endmodule

// ===== bench/qpi_framing_props.sv
// concurrent checks on the flash framing block ports
`timescale 1ns/1ns
module qpi_framing_props (
  input wire logic clock, // block clock
  input wire logic arst_n, // async reset, active low
  input wire logic cs_n, // chip select pin
  input wire logic [3:0] io_oe, // lane enables
  input wire logic rd_take, // data byte taken
  input wire logic cmd_strobe, // command byte seen
  input wire logic addr_strobe, // address captured
  input wire logic [23:0] addr, // captured address
  input wire logic [7:0] mode_bits, // captured mode bits
  input wire logic sec_valid, // security address legal
  input wire logic [1:0] sec_sel, // security register number
  input wire logic [9:0] sec_offset, // byte in register
  input wire logic power_down, // deep power-down
  input wire logic wake // release decoded
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // a byte spans many block clocks, so strobes stay apart
  sequence s_no_cmd;
    !cmd_strobe [*8];
  endsequence
  sequence s_addr_held;
    ($stable(addr) && $stable(mode_bits)) [*4];
  endsequence
  chk_cmd_pulse: assert property (cmd_strobe |=> s_no_cmd)
    else $error("command strobe repeated too soon");
  chk_addr_hold: assert property (addr_strobe |=> s_addr_held)
    else $error("address moved after capture");
  chk_take_gap: assert property (rd_take |=> !rd_take [*3])
    else $error("data bytes taken too fast");
  chk_oe_release: assert property (cs_n [*6] |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  chk_oe_shape: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable pattern");
  chk_oe_select: assert property ($rose(|io_oe) |-> !cs_n)
    else $error("drive started without select");
  chk_sec_fields: assert property (sec_valid |-> addr[23:16] == 8'h00 && addr[11:10] == 2'h0
    && sec_offset == addr[9:0])
    else $error("security address fields wrong");
  chk_sec_select: assert property (sec_valid |-> addr[15:14] == 2'h0 && sec_sel == addr[13:12]
    && sec_sel != 2'h0)
    else $error("security register select wrong");
  chk_wake_release: assert property (wake |-> ##[0:4] !power_down)
    else $error("release did not leave power-down");
  chk_pd_quiet: assert property (power_down |-> io_oe == 4'h0)
    else $error("output while powered down");
endmodule
bind qpi_flash_command_framing qpi_framing_props u_qpi_framing_props (.clock(clock), .arst_n(arst_n),
  .cs_n(cs_n), .io_oe(io_oe), .rd_take(rd_take), .cmd_strobe(cmd_strobe), .addr_strobe(addr_strobe),
  .addr(addr), .mode_bits(mode_bits), .sec_valid(sec_valid), .sec_sel(sec_sel), .sec_offset(sec_offset),
  .power_down(power_down), .wake(wake));

// ===== bench/flash_host_model.sv
// host flash controller model driving clock, select and lanes
`timescale 1ns/1ns
module flash_host_model (
  input wire logic clock, // block clock
  input wire logic [3:0] io_out, // device lane values
  input wire logic [3:0] io_oe, // device lane enables
  output logic sclk, // serial clock
  output logic cs_n, // chip select, active low
  output logic [3:0] io_in // resolved lane levels
);
  logic [3:0] drv_r = 4'h0;
  logic hoe_r = 1'b0;
  logic [3:0] flt_r = 4'h5;
  initial sclk = 1'b0;
  initial cs_n = 1'b1;
  // released lanes wander so a stale level never passes
  always @(posedge clock)
    flt_r <= ~flt_r;
  assign io_in = (io_oe & io_out) | (~io_oe & (hoe_r ? drv_r : flt_r));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one serial clock; lanes set after the fall, read late in the high phase
  task automatic cyc(input logic en, input logic [3:0] v, output logic [3:0] got);
    hoe_r <= en;
    drv_r <= v;
    tick(4);
    sclk <= 1'b1;
    tick(4);
    got = io_in;
    sclk <= 1'b0;
  endtask
  task automatic xfer(input logic en, input logic [7:0] b, input int w, output logic [7:0] got);
    logic [3:0] g;
    logic [3:0] v;
    got = 8'h00;
    for (int i = 8 - w; i >= 0; i -= w)
    begin
      // high group first, odd bit on the upper lane
      v = (w == 4) ? b[i+:4] : (w == 2) ? {2'b11, b[i+:2]} : {3'b111, b[i]};
      cyc(en, v, g);
      if (w == 4) got[i+:4] = g;
      else if (w == 2) got[i+:2] = g[1:0];
      else got[i] = g[1];
    end
  endtask
  // dummy clocks with the lanes released
  task automatic dummy(input int n);
    logic [3:0] g;
    repeat (n) cyc(1'b0, 4'h0, g);
  endtask
  task automatic start();
    cs_n <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    hoe_r <= 1'b0;
    cs_n <= 1'b1;
    tick(6);
  endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the flash command framing block
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] cfg_value = 8'hC3;
  logic [7:0] rd_data = 8'h00;
  logic sclk, cs_n, rd_take, cmd_strobe, addr_strobe, sec_valid, qpi_mode, power_down, wake, vsr_armed;
  logic [3:0] io_in, io_out, io_oe;
  logic [23:0] rd_addr, addr;
  logic [7:0] mode_bits, cmd_code;
  logic [1:0] sec_sel;
  logic [9:0] sec_offset;
  logic [7:0] g;
  int bad_count = 0;
  int compares = 0;
  int n_take = 0;
  int n_cmd = 0;
  int n_addr = 0;
  int n_wake = 0;
  always #25 clock = ~clock;
  // memory stand-in: byte value derived from its address
  always @(posedge clock)
    rd_data <= rd_addr[7:0] ^ 8'h3C;
  // strobe counters, read mid-cycle so each one-cycle pulse counts once
  always @(negedge clock)
  begin
    if (rd_take === 1'b1) n_take++;
    if (cmd_strobe === 1'b1) n_cmd++;
    if (addr_strobe === 1'b1) n_addr++;
    if (wake === 1'b1) n_wake++;
  end
  // id value is arbitrary
  qpi_flash_command_framing #(.DEVICE_ID(8'h96)) u_qpi_flash_command_framing (.clock(clock), .arst_n(arst_n),
    .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .cfg_value(cfg_value),
    .rd_data(rd_data), .rd_take(rd_take), .rd_addr(rd_addr), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .addr_strobe(addr_strobe), .addr(addr), .mode_bits(mode_bits), .sec_valid(sec_valid), .sec_sel(sec_sel),
    .sec_offset(sec_offset), .qpi_mode(qpi_mode), .power_down(power_down), .wake(wake), .vsr_armed(vsr_armed));
  flash_host_model host (.clock(clock), .io_out(io_out), .io_oe(io_oe), .sclk(sclk), .cs_n(cs_n), .io_in(io_in));
  task automatic lone(input logic [7:0] op, input int w);
    host.start();
    host.xfer(1'b1, op, w, g);
    host.stop();
  endtask
  task automatic read_frame(input logic [7:0] op, input logic [23:0] a, input int nmode, input int ndum, input int n);
    int take0;
    int cmd0;
    int addr0;
    take0 = n_take;
    cmd0 = n_cmd;
    addr0 = n_addr;
    host.start();
    host.xfer(1'b1, op, 4, g);
    for (int k = 16; k >= 0; k -= 8) host.xfer(1'b1, a[k+:8], 4, g);
    if (nmode > 0) host.xfer(1'b1, 8'h5C, 4, g);
    host.dummy(ndum);
    for (int k = 0; k < n; k++)
    begin
      host.xfer(1'b0, 8'h00, 4, g);
      `CHK(g, (a[7:0] + k[7:0]) ^ 8'h3C)
    end
    `CHK(io_oe, 4'hF)
    `CHK(addr, a)
    host.stop();
    `CHK(io_oe, 4'h0)
    `CHK(n_take - take0, n)
    `CHK(rd_addr, a + 24'(n))
    `CHK(n_cmd - cmd0, 1)
    `CHK(cmd_code, op)
    `CHK(n_addr - addr0, 1)
  endtask
  task automatic t_reads();
    read_frame(8'hEB, 24'h123456, 1, 4, 2);
    `CHK(mode_bits, 8'h5C)
    read_frame(8'hE7, 24'h000102, 1, 2, 2);
    read_frame(8'h0C, 24'h0000F0, 0, 4, 3);
    $display("test reads done");
  endtask
  task automatic t_cfg();
    logic [7:0] ops [2] = '{8'h45, 8'h15};
    foreach (ops[i])
    begin
      host.start();
      host.xfer(1'b1, ops[i], 4, g);
      repeat (3)
      begin
        host.xfer(1'b0, 8'h00, 4, g);
        `CHK(g, 8'hC3)
      end
      host.stop();
    end
    $display("test cfg done");
  endtask
  task automatic t_sec();
    logic [23:0] tab [5] = '{24'h002155, 24'h0033FF, 24'h004000, 24'h001400, 24'h013000};
    logic ok;
    foreach (tab[i])
    begin
      host.start();
      host.xfer(1'b1, 8'h44, 4, g);
      for (int k = 16; k >= 0; k -= 8) host.xfer(1'b1, tab[i][k+:8], 4, g);
      host.stop();
      ok = tab[i][23:16] == 8'h00 && tab[i][11:10] == 2'h0 && tab[i][15:12] inside {4'h1, 4'h2, 4'h3};
      `CHK(sec_valid, ok)
      if (ok) `CHK({sec_sel, sec_offset}, {tab[i][13:12], tab[i][9:0]})
    end
    $display("test sec done");
  endtask
  task automatic t_vsr();
    lone(8'h50, 4);
    `CHK(vsr_armed, 1'b1)
    host.start();
    host.xfer(1'b1, 8'h01, 4, g);
    host.xfer(1'b1, 8'h00, 4, g);
    host.stop();
    `CHK(vsr_armed, 1'b0)
    $display("test vsr done");
  endtask
  task automatic t_power();
    int w0;
    lone(8'hB9, 4);
    `CHK(power_down, 1'b1)
    host.start();
    host.xfer(1'b1, 8'h45, 4, g);
    host.xfer(1'b0, 8'h00, 4, g);
    `CHK(io_oe, 4'h0)
    host.stop();
    w0 = n_wake;
    lone(8'hAB, 4);
    `CHK(power_down, 1'b0)
    `CHK(n_wake - w0, 1)
    lone(8'hB9, 4);
    host.start();
    host.xfer(1'b1, 8'hAB, 4, g);
    host.dummy(6);
    repeat (2)
    begin
      host.xfer(1'b0, 8'h00, 4, g);
      `CHK(g, 8'h96)
    end
    host.stop();
    `CHK(power_down, 1'b0)
    $display("test power done");
  endtask
  task automatic t_lanes();
    logic [23:0] da = 24'h00ABCD;
    lone(8'hFF, 4);
    `CHK(qpi_mode, 1'b0)
    host.start();
    host.xfer(1'b1, 8'hBB, 1, g);
    for (int k = 16; k >= 0; k -= 8) host.xfer(1'b1, da[k+:8], 2, g);
    host.xfer(1'b1, 8'h00, 2, g);
    host.xfer(1'b0, 8'h00, 2, g);
    `CHK(g, 8'hCD ^ 8'h3C)
    `CHK(addr, da)
    host.stop();
    lone(8'h38, 1);
    `CHK(qpi_mode, 1'b1)
    $display("test lanes done");
  endtask
  task automatic results();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clock);
    bad_count++;
    results();
  end
  initial
  begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK({qpi_mode, power_down, vsr_armed, io_oe}, 7'h40)
    t_reads();
    t_cfg();
    t_sec();
    t_vsr();
    t_power();
    t_lanes();
    results();
  end
endmodule
